// ==== design/tma_defs.vh ====
// register offsets, field positions and reset values of the timer a channel
`ifndef TMA_DEFS_VH
`define TMA_DEFS_VH
`define TMA_ADDR_W          12
`define TMA_OFS_MODE_LO     12'hfa0
`define TMA_OFS_MODE_HI     12'hfa1
`define TMA_OFS_COUNT_LO    12'hfa4
`define TMA_OFS_COUNT_HI    12'hfa5
`define TMA_OFS_COMPARE_LO  12'hfa8
`define TMA_OFS_COMPARE_HI  12'hfa9
`define TMA_OFS_FLAGS       12'hf92
`define TMA_MODE_CASCADE    7
`define TMA_MODE_SRC_HI     6
`define TMA_MODE_SRC_LO     4
`define TMA_MODE_RESTART    3
`define TMA_MODE_ENABLE     2
`define TMA_FLAG_PIN_OE     3
`define TMA_FLAG_OTHER_OE   2
`define TMA_FLAG_OTHER_TL   0
`define TMA_MODE_RESET      8'h00
`define TMA_COUNT_RESET     8'h00
`define TMA_COMPARE_RESET   8'hff
`define TMA_SRC_EXT_RISE    3'h0
`define TMA_SRC_EXT_FALL    3'h1
`define TMA_SRC_DIV1024     3'h4
`define TMA_SRC_DIV64       3'h5
`define TMA_SRC_DIV16       3'h6
`define TMA_SRC_DIV1        3'h7
`define TMA_PRESCALE_W      10
`endif

// ==== design/tma_channel.v ====
// 8-bit timer a channel: mode, count, compare, output flags and toggle output
`timescale 1ns/1ps
`include "tma_defs.vh"

// Functional notes
// - on match the toggle latch inverts and drives the output pin when enabled
// - toggle signal always goes to serial clock selector, regardless of output enable
// - external input edges divided by compare setting appear on the output pin
// - mode register takes nibble writes; restart bit also takes single-bit writes
// - reset clears all mode bits, channel disabled
// - mode bit 7 picks cascaded 16-bit or two 8-bit counters
// - restart bit clears counter, request flag, toggle latch; self-clears
// - enable bit low holds counter; high lets it count
// - mode bits 6..4 choose external edge or system clock division
// - mode bits 1 and 0 always read zero
// - counter is read-only and resets to 00h
// - enabled counter increments once per selected source pulse
// - counter compared after increment; equality sets request flag and interrupt
// - compare register write-only, resets to ffh
// - match period is compare value plus one source periods
// - flag word: pin enable bit 3, other enable bit 2, zero, other latch
// - reset clears pin output enable, blocking the toggle output
// - toggle latch cleared on start, held while disabled
// - after a match the counter returns to 00h and keeps counting
// - match reaches processor only when interrupt enable flag is set
module tma_channel #(
	parameter DATA_W = 8
)(
	input  wire                    clk,
	input  wire                    reset_n,
	input  wire [`TMA_ADDR_W-1:0]  busAddr,
	input  wire                    busWrite,
	input  wire                    busBitWrite,
	input  wire [2:0]              busBitSel,
	input  wire                    busBitVal,
	input  wire [DATA_W-1:0]       busWdata,
	input  wire                    busRead,
	output reg  [DATA_W-1:0]       busRdata,
	input  wire                    externalCountInput,
	input  wire                    matchInterruptEnable,
	input  wire                    matchRequestClear,
	input  wire                    otherChannelToggleLatch,
	output reg                     matchRequestFlag,
	output reg                     matchInterrupt,
	output reg                     toggleOutputPin,
	output reg                     serialShiftClock,
	output reg                     cascadeMode
);
	reg  [1:0]                 rstSync_q;
	wire                       rstN;
	reg  [DATA_W-1:0]          mode_q;
	reg  [DATA_W-1:0]          count_q;
	reg  [DATA_W-1:0]          count_d;
	reg  [DATA_W-1:0]          compare_q;
	reg                        pinOutputEnable_q;
	reg                        otherTimerOutputEnable_q;
	reg                        toggleLatch_q;
	reg                        restart_q;
	reg  [`TMA_PRESCALE_W-1:0] prescale_q;
	reg  [`TMA_PRESCALE_W-1:0] prescale_d;
	reg  [1:0]                 extSync_q;
	reg                        extLast_q;
	reg                        tick;
	wire [2:0]                 src;
	wire                       enabled;
	wire                       match;
	wire                       atCompare;
	wire                       step;
	wire                       modeLoWr;
	wire                       modeHiWr;

	// reset released through two flops
	always @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			rstSync_q <= 2'h0;
		else
			rstSync_q <= {rstSync_q[0], 1'b1};
	end
	assign rstN = rstSync_q[1];

	// nibble-wide byte: low nibble and high nibble sit at the two addresses
	function isAddr;
		input [`TMA_ADDR_W-1:0] a;
		input [`TMA_ADDR_W-1:0] lo;
		begin
			isAddr = (a == lo);
		end
	endfunction

	// single-bit write aimed at one bit of one nibble
	function isBitWr;
		input                   en;
		input [`TMA_ADDR_W-1:0] a;
		input [2:0]             sel;
		input [`TMA_ADDR_W-1:0] target;
		input integer           bitPos;
		begin
			isBitWr = en && (a == target) && (sel == bitPos);
		end
	endfunction

	assign modeLoWr = busWrite && isAddr(busAddr, `TMA_OFS_MODE_LO);
	assign modeHiWr = busWrite && isAddr(busAddr, `TMA_OFS_MODE_HI);
	assign src      = mode_q[`TMA_MODE_SRC_HI:`TMA_MODE_SRC_LO];
	assign enabled  = mode_q[`TMA_MODE_ENABLE];

	// mode register; restart is a one-cycle command, never stored
	always @(posedge clk or negedge rstN)
	begin
		if (!rstN)
		begin
			mode_q    <= `TMA_MODE_RESET;
			restart_q <= 1'b0;
		end
		else
		begin
			restart_q <= 1'b0;
			if (modeLoWr)
			begin
				// bits 1..0 forced low
				mode_q[3:0] <= {1'b0, busWdata[2], 2'b00};
				restart_q   <= busWdata[`TMA_MODE_RESTART];
			end
			if (modeHiWr)
				mode_q[7:4] <= busWdata[3:0];
			if (isBitWr(busBitWrite, busAddr, busBitSel, `TMA_OFS_MODE_LO,
				`TMA_MODE_RESTART) && busBitVal)
				restart_q <= 1'b1;
		end
	end

	// compare register, byte written as two nibbles
	always @(posedge clk or negedge rstN)
	begin
		if (!rstN)
			compare_q <= `TMA_COMPARE_RESET;
		else
		begin
			if (busWrite && isAddr(busAddr, `TMA_OFS_COMPARE_LO))
				compare_q[3:0] <= busWdata[3:0];
			if (busWrite && isAddr(busAddr, `TMA_OFS_COMPARE_HI))
				compare_q[7:4] <= busWdata[3:0];
		end
	end

	// flag word: enables take nibble or single-bit writes
	always @(posedge clk or negedge rstN)
	begin
		if (!rstN)
		begin
			pinOutputEnable_q        <= 1'b0;
			otherTimerOutputEnable_q <= 1'b0;
		end
		else if (isAddr(busAddr, `TMA_OFS_FLAGS))
		begin
			// a nibble write beats a bit write landing in the same cycle
			if (busWrite)
			begin
				pinOutputEnable_q        <= busWdata[`TMA_FLAG_PIN_OE];
				otherTimerOutputEnable_q <= busWdata[`TMA_FLAG_OTHER_OE];
			end
			else if (isBitWr(busBitWrite, busAddr, busBitSel, `TMA_OFS_FLAGS, `TMA_FLAG_PIN_OE))
				pinOutputEnable_q <= busBitVal;
			else if (isBitWr(busBitWrite, busAddr, busBitSel, `TMA_OFS_FLAGS, `TMA_FLAG_OTHER_OE))
				otherTimerOutputEnable_q <= busBitVal;
		end
	end

	// external input: two flops, then edge detect on the second
	always @(posedge clk or negedge rstN)
	begin
		if (!rstN)
		begin
			extSync_q <= 2'h0;
			extLast_q <= 1'b0;
		end
		else
		begin
			extSync_q <= {extSync_q[0], externalCountInput};
			extLast_q <= extSync_q[1];
		end
	end

	// free-running prescaler; restart realigns it so the first interval is whole
	always @*
	begin
		prescale_d = prescale_q + {{(`TMA_PRESCALE_W-1){1'b0}}, 1'b1};
		if (restart_q)
			prescale_d = {`TMA_PRESCALE_W{1'b0}};
	end

	always @(posedge clk or negedge rstN)
	begin
		if (!rstN)
			prescale_q <= {`TMA_PRESCALE_W{1'b0}};
		else
			prescale_q <= prescale_d;
	end

	// source select; undefined codes 010/011 give no pulses
	always @*
	begin
		case (src)
			`TMA_SRC_EXT_RISE: tick = extSync_q[1] && !extLast_q;
			`TMA_SRC_EXT_FALL: tick = !extSync_q[1] && extLast_q;
			`TMA_SRC_DIV1024:  tick = (prescale_q == 10'h3ff);
			`TMA_SRC_DIV64:    tick = (prescale_q[5:0] == 6'h3f);
			`TMA_SRC_DIV16:    tick = (prescale_q[3:0] == 4'hf);
			`TMA_SRC_DIV1:     tick = 1'b1;
			default:           tick = 1'b0;
		endcase
	end

	// the count dwells on the compare value for one source period before it wraps;
	// that dwell is what stretches the interval to compare plus one
	assign atCompare = (count_q == compare_q);
	// a restart owns its cycle, so no match can sneak past the clear
	assign step      = enabled && tick && !restart_q;
	assign match     = step && ((count_q + 8'h01) == compare_q);

	// next count: restart, wrap after the dwell, or one step per tick
	always @*
	begin
		count_d = count_q;
		if (restart_q)
			count_d = `TMA_COUNT_RESET;
		else if (step && atCompare)
			count_d = `TMA_COUNT_RESET;
		else if (step)
			count_d = count_q + 8'h01;
		// disabled or no tick: value held
	end

	always @(posedge clk or negedge rstN)
	begin
		if (!rstN)
			count_q <= `TMA_COUNT_RESET;
		else
			count_q <= count_d;
	end

	// toggle latch and request flag; a match beats a same-cycle clear
	always @(posedge clk or negedge rstN)
	begin
		if (!rstN)
		begin
			toggleLatch_q    <= 1'b0;
			matchRequestFlag <= 1'b0;
		end
		else if (restart_q)
		begin
			toggleLatch_q    <= 1'b0;
			matchRequestFlag <= 1'b0;
		end
		else
		begin
			if (match)
				toggleLatch_q <= !toggleLatch_q;
			if (match)
				matchRequestFlag <= 1'b1;
			else if (matchRequestClear)
				matchRequestFlag <= 1'b0;
		end
	end

	// registered outputs and read port
	always @(posedge clk or negedge rstN)
	begin
		if (!rstN)
		begin
			toggleOutputPin  <= 1'b0;
			serialShiftClock <= 1'b0;
			matchInterrupt   <= 1'b0;
			cascadeMode      <= 1'b0;
			busRdata         <= {DATA_W{1'b0}};
		end
		else
		begin
			// pin and serial copies share one stage of delay, so they agree whenever the pin output is enabled
			// gated copy; drives pin in timer and divider modes
			toggleOutputPin  <= pinOutputEnable_q && toggleLatch_q;
			serialShiftClock <= toggleLatch_q;
			matchInterrupt   <= match && matchInterruptEnable;
			cascadeMode      <= mode_q[`TMA_MODE_CASCADE];
			busRdata         <= {DATA_W{1'b0}};
			if (busRead)
			begin
				if (isAddr(busAddr, `TMA_OFS_COUNT_LO))
					busRdata <= {4'h0, count_q[3:0]};
				else if (isAddr(busAddr, `TMA_OFS_COUNT_HI))
					busRdata <= {4'h0, count_q[7:4]};
				else if (isAddr(busAddr, `TMA_OFS_FLAGS))
					busRdata <= {4'h0, pinOutputEnable_q, otherTimerOutputEnable_q,
						1'b0, otherChannelToggleLatch};
			end
		end
	end
endmodule

// ==== tb/tma_channel_asserts.sv ====
// port checks for the timer a channel
`timescale 1ns/1ps
module tma_channel_asserts (
	input wire        clk,
	input wire        reset_n,
	input wire [11:0] busAddr,
	input wire        busWrite,
	input wire        busBitWrite,
	input wire [2:0]  busBitSel,
	input wire        busBitVal,
	input wire        busRead,
	input wire [7:0]  busWdata,
	input wire [7:0]  busRdata,
	input wire        matchInterruptEnable,
	input wire        matchRequestClear,
	input wire        matchRequestFlag,
	input wire        matchInterrupt,
	input wire        toggleOutputPin,
	input wire        serialShiftClock,
	input wire        cascadeMode
);
	wire rs = busAddr == 12'hfa0 && (busWrite && busWdata[3] ||
		busBitWrite && busBitSel == 3'h3 && busBitVal);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	a_irq_pulse: assert property (matchInterrupt |=> !matchInterrupt)
		else $error("interrupt pulse too long");
	a_irq_flag: assert property (matchInterrupt |-> matchRequestFlag)
		else $error("interrupt without flag");
	a_irq_gated: assert property (matchInterrupt |->
		matchInterruptEnable || $past(matchInterruptEnable)) else $error("irq while masked");
	a_latch_cause: assert property ($rose(serialShiftClock) |-> $past(matchRequestFlag))
		else $error("latch rose without match");
	a_pin_gated: assert property (toggleOutputPin |->
		serialShiftClock || $past(serialShiftClock)) else $error("pin high, latch low");
	a_restart_clear: assert property (rs |-> ##2 !matchRequestFlag ##1 !serialShiftClock)
		else $error("restart did not clear");
	a_flag_fall: assert property ($fell(matchRequestFlag) |->
		$past(matchRequestClear) || $past(rs) || $past(rs, 2) || $past(rs, 3))
		else $error("flag fell without cause");
	a_cascade_src: assert property ($changed(cascadeMode) |->
		$past(busWrite && busAddr == 12'hfa1, 2)) else $error("mode bit changed alone");
	a_rdata_idle: assert property (!$past(busRead) |-> busRdata == 8'h00)
		else $error("read data without read");
	cover property (matchInterrupt);
	cover property ($rose(toggleOutputPin));
	cover property (rs);
endmodule
bind tma_channel tma_channel_asserts chk (.*);

// ==== tb/tma_ext_source.sv ====
// far side count source: square wave of eight clocks while running
`timescale 1ns/1ps
module tma_ext_source (
	input  wire clk,
	input  wire run,
	output reg  extIn
);
	reg [1:0] phase_q = 2'h0;
	initial extIn = 1'b0;
	// holds still when not running, so no stray edges between phases
	always @(posedge clk)
		if (run)
		begin
			phase_q <= phase_q + 2'h1;
			if (phase_q == 2'h3)
				extIn <= #1 !extIn;
		end
endmodule

// ==== tb/timer_a_8bit_counter_divider_test.sv ====
// self-checking bench for the timer a channel
`timescale 1ns/1ps
module timer_a_8bit_counter_divider_test;
	reg clk = 0, reset_n = 0, wr_ = 0, bw_ = 0, bv = 0, rd_ = 0, clr = 0, run = 0, oe = 0, ie = 1;
	reg [11:0] ad = 0;
	reg [2:0] bs = 0, s;
	reg [7:0] wd = 0, v, w;
	wire [7:0] rdt;
	wire ext, flag, irq, pin, sck, casc;
	integer fail_count = 0, checks_done = 0, seed = 17, i, n, cmp;
	always #25 clk = ~clk;
	tma_ext_source far (.clk(clk), .run(run), .extIn(ext));
	tma_channel uut (.clk(clk), .reset_n(reset_n), .busAddr(ad), .busWrite(wr_),
		.busBitWrite(bw_), .busBitSel(bs), .busBitVal(bv), .busWdata(wd), .busRead(rd_),
		.busRdata(rdt), .externalCountInput(ext), .matchInterruptEnable(ie),
		.matchRequestClear(clr), .otherChannelToggleLatch(1'b1), .matchRequestFlag(flag),
		.matchInterrupt(irq), .toggleOutputPin(pin), .serialShiftClock(sck), .cascadeMode(casc));
	task chk(input [15:0] g, input [15:0] e);
		begin
			checks_done = checks_done + 1;
			if (g !== e)
			begin
				fail_count = fail_count + 1;
				$display("unexpected at %0t: got %h expected %h", $time, g, e);
			end
		end
	endtask
	task close_out;
		begin
			if (fail_count == 0 && checks_done > 0)
				$display("== PASSED ==");
			else
				$display("== FAILED ==");
			$finish;
		end
	endtask
	task wr(input [11:0] a, input [3:0] d);
		begin
			@(posedge clk) #1;
			ad = a;
			wd = {4'h0, d};
			wr_ = 1;
			@(posedge clk) #1 wr_ = 0;
		end
	endtask
	task bwr(input [11:0] a, input [2:0] b, input x);
		begin
			@(posedge clk) #1;
			ad = a;
			bs = b;
			bv = x;
			bw_ = 1;
			@(posedge clk) #1 bw_ = 0;
		end
	endtask
	task rd(input [11:0] a, output [7:0] d);
		begin
			@(posedge clk) #1;
			ad = a;
			rd_ = 1;
			@(posedge clk) #1 rd_ = 0;
			d = rdt;
		end
	endtask
	task wait_irq;
		begin
			n = 0;
			@(posedge clk) #1;
			while (irq !== 1'b1 && n < 30000)
			begin
				@(posedge clk) #1;
				n = n + 1;
			end
			if (n >= 30000)
			begin
				fail_count = fail_count + 1;
				close_out;
			end
		end
	endtask
	function integer div_of(input [2:0] x);
		div_of = x == 7 ? 1 : x == 6 ? 16 : x == 5 ? 64 : x == 4 ? 1024 : 8;
	endfunction
	initial
	begin
		repeat (12) @(posedge clk);
		#1 reset_n = 1;
		repeat (3) @(posedge clk);
		rd(12'hfa4, v);
		chk(v, 8'h00);
		rd(12'hf92, v);
		chk(v, 8'h01);
		wr(12'hfa1, 4'h7);
		wr(12'hfa0, 4'hc);
		wait_irq;
		wait_irq;
		chk(n + 1, 256);
		for (i = 0; i < 6; i = i + 1)
		begin
			s = i < 4 ? 7 - i : i - 4;
			cmp = 2 + {$random(seed)} % 8;
			run = s < 4;
			wr(12'hfa1, 4'h7);
			wr(12'hfa8, cmp[3:0]);
			wr(12'hfa9, cmp[7:4]);
			wr(12'hfa1, {1'b0, s});
			wr(12'hfa0, 4'hc);
			oe = i != 5;
			bwr(12'hf92, 3'h3, oe);
			rd(12'hf92, v);
			chk(v, {4'h0, oe, 3'h1});
			wait_irq;
			repeat (2) @(posedge clk) #1;
			w = sck;
			wait_irq;
			chk(n + 3, (cmp + 1) * div_of(s));
			chk(flag, 1);
			repeat (2) @(posedge clk) #1;
			chk(sck, !w[0]);
			chk(pin, sck & oe);
		end
		run = 0;
		wr(12'hfa0, 4'h0);
		rd(12'hfa4, v);
		w = sck;
		@(posedge clk) #1 clr = 1;
		@(posedge clk) #1 clr = 0;
		chk(flag, 0);
		wr(12'hfa1, 4'h7);
		repeat (20) @(posedge clk) #1;
		chk(sck, w);
		rd(12'hfa4, w);
		chk(w, v);
		ie = 0;
		wr(12'hfa0, 4'h4);
		for (i = 0; i < 12; i = i + 1)
			@(posedge clk) #1 chk(irq, 0);
		chk(flag, 1);
		wr(12'hfa1, 4'h4);
		bwr(12'hfa0, 3'h3, 1);
		repeat (4) @(posedge clk) #1;
		rd(12'hfa4, v);
		chk({v, flag, sck}, 10'h0);
		wr(12'hfa1, 4'h8);
		@(posedge clk) #1;
		chk(casc, 1);
		wr(12'hfa1, 4'h7);
		@(posedge clk) #1;
		chk(casc, 0);
		close_out;
	end
endmodule
